// ### common/reset_seq_pkg.sv
// Constants, register map and state codes shared by the reset sequencer.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`default_nettype none
package reset_seq_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADR_CAUSE  = 8'h00;   // reset_cause_flags
	localparam logic [7:0] ADR_STATUS = 8'h04;   // processor_status
	localparam logic [7:0] ADR_BOCTL  = 8'h08;   // brownout_control
	localparam logic [7:0] ADR_WDCTL  = 8'h0C;   // watchdog_control
	localparam logic [7:0] ADR_CONFIG = 8'h10;   // sequencer configuration
	localparam logic [7:0] ADR_SEQST  = 8'h14;   // sequencer state, read only

	// ==========================================================
	// reset_cause_flags bit positions
	localparam int CF_OVF = 7;
	localparam int CF_UNF = 6;
	localparam int CF_WDT = 4;
	localparam int CF_PIN = 3;
	localparam int CF_INSTR = 2;
	localparam int CF_POR = 1;
	localparam int CF_BOR = 0;
	localparam logic [7:0] CF_MASK    = 8'hDF;   // Bit 5 unimplemented
	localparam logic [7:0] CF_POR_VAL = 8'h1C;   // 00-1 1100

	// ==========================================================
	// processor_status bit positions
	localparam int ST_TO = 4;
	localparam int ST_PWDN = 3;
	localparam logic [7:0] ST_SW_MASK = 8'h07;   // Bits software may write
	localparam logic [7:0] ST_POR_VAL = 8'h18;   // 1 1000

	// ==========================================================
	// brownout_control, watchdog_control, configuration
	localparam int BC_SWEN = 7;
	localparam int BC_FAST = 6;
	localparam int BC_RDY  = 0;
	localparam logic [7:0] WC_MASK    = 8'h3F;
	localparam logic [7:0] WC_RST_VAL = 8'h16;
	localparam int CFG_PWRT_N  = 0;   // power_up_delay_enable_n
	localparam int CFG_OSC_WAIT = 1;  // Oscillator needs start-up timer
	localparam int CFG_PIN_EN  = 2;   // External reset pin enabled
	localparam int CFG_STK_EN  = 3;   // stack_reset_enable
	localparam int CFG_LPB_EN  = 4;   // low_power_brownout enable
	localparam logic [7:0] CFG_MASK    = 8'h1F;
	localparam logic [7:0] CFG_RST_VAL = 8'h05;

	// ==========================================================
	// Program counter vectors
	localparam logic [14:0] PC_RESET_VEC = 15'h0000;
	localparam logic [14:0] PC_IRQ_VEC   = 15'h0004;

	// ==========================================================
	// Asynchronous input positions in the synchroniser vector
	localparam int NSYNC   = 7;
	localparam int SY_POR  = 0;
	localparam int SY_BOR  = 1;
	localparam int SY_LPB  = 2;
	localparam int SY_PINN = 3;
	localparam int SY_BRDY = 4;
	localparam int SY_LFC  = 5;
	localparam int SY_OSC  = 6;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		SEQ_PWRUP  = 3'b000,
		SEQ_RESET  = 3'b001,
		SEQ_RUN    = 3'b010,
		SEQ_SLEEP  = 3'b011,
		SEQ_VECTOR = 3'b100
	} seq_state_t;

endpackage : reset_seq_pkg
`default_nettype wire

// ### src/startup_timer.sv
// Start-up delay counter ticking on a qualified clock-enable pulse.
// Assumes tick_i is a one-cycle pulse in the clk_i domain.
`timescale 1ns/100ps
`default_nettype none
module startup_timer #(
	parameter int COUNT = 2048
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic clear_i,
	input  wire logic enable_i,
	input  wire logic tick_i,
	// Status
	output logic      done_o
);
	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT);

	logic [W-1:0] cnt_r;

	// ==========================================================
	// Count ticks until the terminal value, restart on clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_i)
			cnt_r <= '0;
		else if (tick_i && cnt_r != LAST)
			cnt_r <= cnt_r + W'(1);
	end

	// A disabled timer counts as already expired
	assign done_o = !enable_i || (cnt_r == LAST);

endmodule : startup_timer
`default_nettype wire

// ### src/reset_sequencer.sv
// Reset cause tracking and start-up sequencing with a Wishbone register file.
// Assumes rst_i is the power-on reset; detector and pin inputs are asynchronous.
//
// Behaviour
// - Programming mode exit acts as power-on reset
// - Optional power-up delay, active-low enable bit
// - Run needs timers done and pin released
// - Timers ignore pin; run on pin release
// - Every reset updates cause flags
// - Power-on sets timeout and power-down flags
// - Power-on and brown-out load cause register
// - Stack overflow sets bit 7 sticky
// - Stack underflow sets bit 6 sticky
// - Watchdog reset clears bit 4
// - Pin reset clears bit 3
// - Reset instruction clears bit 2
// - Power-on clears bit 1, firmware sets
// - Brown-out or power-on clears bit 0
// - Watchdog run reset versus sleep wake
// - Interrupt wake sets timeout, clears power-down
// - Pin reset in sleep: timeout 1, power-down 0
// - Resets load 0000h; interrupt wake vectors 0004h
// - Unimplemented status bits read zero
// - Stack resets only when enabled
// - Low-power brown-out ORed into brown-out
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer
	import reset_seq_pkg::*;
#(
	parameter int PWRT_TICKS = 2048,   // Low-frequency oscillator edges
	parameter int OSC_TICKS  = 1024    // Selected oscillator edges
) (
	// Clock and power-on reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Asynchronous detectors, pin and oscillators
	input  wire logic        por_det_i,
	input  wire logic        bor_det_i,
	input  wire logic        low_power_brownout_det_i,
	input  wire logic        external_reset_pin_n_i,
	input  wire logic        bor_ready_i,
	input  wire logic        lf_osc_i,
	input  wire logic        sel_osc_i,
	// Core events, one-cycle pulses, and the global interrupt enable level
	input  wire logic        prog_exit_i,
	input  wire logic        wdt_timeout_i,
	input  wire logic        reset_instr_i,
	input  wire logic        stack_ovf_i,
	input  wire logic        stack_unf_i,
	input  wire logic        sleep_enter_i,
	input  wire logic        irq_wake_i,
	input  wire logic        global_irq_enable_i,
	// Core control
	output logic             core_reset_o,
	output logic             core_run_o,
	output logic             pc_load_o,
	output logic [14:0]      pc_value_o,
	output logic             pc_advance_o,
	output logic             pc_push_o,
	// Register-driven controls
	output logic             sw_bor_enable_o,
	output logic             bor_fast_start_o,
	output logic [4:0]       wdt_prescale_o,
	output logic             wdt_sw_enable_o
);

	// ==========================================================
	// Input synchronisers
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic             lfc_d_r;
	logic             osc_d_r;

	assign async_in = {sel_osc_i, lf_osc_i, bor_ready_i, external_reset_pin_n_i,
	                   low_power_brownout_det_i, bor_det_i, por_det_i};

	// Two flip-flops per asynchronous input
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++)
		begin : g_sync
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
				end
				else
				begin
					sync1_r[g] <= async_in[g];
					sync2_r[g] <= sync1_r[g];
				end
			end
		end
	endgenerate

	// Delayed oscillator levels for rising-edge detection
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lfc_d_r <= 1'b0;
			osc_d_r <= 1'b0;
		end
		else
		begin
			lfc_d_r <= sync2_r[SY_LFC];
			osc_d_r <= sync2_r[SY_OSC];
		end
	end

	// ==========================================================
	// Registers and reset sources
	logic [7:0]   cause_r;
	logic [7:0]   status_r;
	logic         bc_swen_r;
	logic         bc_fast_r;
	logic [7:0]   wdctl_r;
	logic [7:0]   cfg_r;
	seq_state_t   state_r;
	seq_state_t   state_nxt;

	logic por_evt;
	logic bor_evt;
	logic pin_rst;
	logic stk_rst;
	logic sw_rst;
	logic wr_en;
	logic pwrt_done;
	logic osc_wait_done;
	logic sleeping;

	assign por_evt  = sync2_r[SY_POR] || prog_exit_i;
	assign bor_evt  = sync2_r[SY_BOR] || (sync2_r[SY_LPB] && cfg_r[CFG_LPB_EN]);
	assign pin_rst  = cfg_r[CFG_PIN_EN] && !sync2_r[SY_PINN];
	assign stk_rst  = cfg_r[CFG_STK_EN] && (stack_ovf_i || stack_unf_i);
	assign sleeping = (state_r == SEQ_SLEEP);
	assign sw_rst   = (state_r == SEQ_RUN) && (wdt_timeout_i || reset_instr_i || stk_rst);
	assign wr_en    = cyc_i && stb_i && we_i && ack_o && sel_i[0];   // Lands on ack edge

	// ==========================================================
	// Start-up timers, cleared while a supply reset is held
	startup_timer #(
		.COUNT    (PWRT_TICKS)
	) u_pwrt (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (por_evt || bor_evt),
		.enable_i (!cfg_r[CFG_PWRT_N]),
		.tick_i   (sync2_r[SY_LFC] && !lfc_d_r),
		.done_o   (pwrt_done)
	);

	startup_timer #(
		.COUNT    (OSC_TICKS)
	) u_osc_wait (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (por_evt || bor_evt),
		.enable_i (cfg_r[CFG_OSC_WAIT]),
		.tick_i   (sync2_r[SY_OSC] && !osc_d_r),
		.done_o   (osc_wait_done)
	);

	// ==========================================================
	// Sequencer state machine
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SEQ_PWRUP:
				// Timers run regardless of the pin; release starts at once
				if (!por_evt && !bor_evt && pwrt_done && osc_wait_done && !pin_rst)
					state_nxt = SEQ_RUN;
			SEQ_RESET:
				if (!pin_rst)
					state_nxt = SEQ_RUN;
			SEQ_RUN:
				if (pin_rst || sw_rst)
					state_nxt = SEQ_RESET;
				else if (sleep_enter_i)
					state_nxt = SEQ_SLEEP;
			SEQ_SLEEP:
				if (pin_rst)
					state_nxt = SEQ_RESET;
				else if (irq_wake_i && global_irq_enable_i)
					state_nxt = SEQ_VECTOR;
				else if (irq_wake_i || wdt_timeout_i)
					state_nxt = SEQ_RUN;
			SEQ_VECTOR:
				state_nxt = SEQ_RUN;
			default:
				state_nxt = SEQ_PWRUP;
		endcase
		if (por_evt || bor_evt)
			state_nxt = SEQ_PWRUP;
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_r <= SEQ_PWRUP;
		else
			state_r <= state_nxt;
	end

	// Core hold and run levels
	assign core_reset_o = (state_r == SEQ_PWRUP) || (state_r == SEQ_RESET);
	assign core_run_o   = (state_r == SEQ_RUN);

	// ==========================================================
	// Program counter commands
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pc_load_o    <= 1'b0;
			pc_value_o   <= PC_RESET_VEC;
			pc_advance_o <= 1'b0;
			pc_push_o    <= 1'b0;
		end
		else
		begin
			pc_load_o    <= 1'b0;
			pc_advance_o <= 1'b0;
			pc_push_o    <= 1'b0;
			if ((state_r == SEQ_PWRUP || state_r == SEQ_RESET) && state_nxt == SEQ_RUN)
			begin
				pc_load_o  <= 1'b1;
				pc_value_o <= PC_RESET_VEC;
			end
			else if (sleeping && (state_nxt == SEQ_RUN || state_nxt == SEQ_VECTOR))
				pc_advance_o <= 1'b1;
			else if (state_r == SEQ_VECTOR)
			begin
				pc_push_o  <= 1'b1;
				pc_load_o  <= 1'b1;
				pc_value_o <= PC_IRQ_VEC;
			end
		end
	end

	// ==========================================================
	// Reset cause flags; hardware events win over software writes
	always_ff @(posedge clk_i)
	begin
		if (rst_i || por_evt)
			cause_r <= CF_POR_VAL;
		else if (bor_evt)
		begin
			cause_r <= cause_r & CF_MASK;
			cause_r[CF_OVF] <= 1'b0;
			cause_r[CF_UNF] <= 1'b0;
			cause_r[CF_WDT] <= 1'b1;
			cause_r[CF_PIN] <= 1'b1;
			cause_r[CF_INSTR] <= 1'b1;
			cause_r[CF_BOR] <= 1'b0;
		end
		else
		begin
			if (wr_en && adr_i == ADR_CAUSE)
				cause_r <= dat_i[7:0] & CF_MASK;
			if (stack_ovf_i)
				cause_r[CF_OVF] <= 1'b1;
			if (stack_unf_i)
				cause_r[CF_UNF] <= 1'b1;
			if (wdt_timeout_i && state_r == SEQ_RUN)
				cause_r[CF_WDT] <= 1'b0;
			if (pin_rst && (state_r == SEQ_RUN || sleeping))
				cause_r[CF_PIN] <= 1'b0;
			if (reset_instr_i && state_r == SEQ_RUN)
				cause_r[CF_INSTR] <= 1'b0;
		end
	end

	// ==========================================================
	// Timeout and power-down flags, plus software-owned low bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i || por_evt)
			status_r <= ST_POR_VAL;
		else if (bor_evt)
		begin
			status_r[ST_TO] <= 1'b1;
			status_r[ST_PWDN] <= 1'b1;
		end
		else
		begin
			if (wr_en && adr_i == ADR_STATUS)
				status_r[2:0] <= dat_i[2:0];
			if (pin_rst && sleeping)
			begin
				status_r[ST_TO] <= 1'b1;
				status_r[ST_PWDN] <= 1'b0;
			end
			else if (sleeping && wdt_timeout_i)
			begin
				status_r[ST_TO] <= 1'b0;
				status_r[ST_PWDN] <= 1'b0;
			end
			else if (sleeping && irq_wake_i)
			begin
				status_r[ST_TO] <= 1'b1;
				status_r[ST_PWDN] <= 1'b0;
			end
			else if (state_r == SEQ_RUN && wdt_timeout_i)
				status_r[ST_TO] <= 1'b0;
			else if (state_r == SEQ_RUN && sleep_enter_i)
			begin
				status_r[ST_TO] <= 1'b1;
				status_r[ST_PWDN] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Brown-out and watchdog control, reloaded on supply resets
	always_ff @(posedge clk_i)
	begin
		if (rst_i || por_evt || bor_evt)
		begin
			bc_swen_r <= 1'b1;
			bc_fast_r <= 1'b0;
			wdctl_r   <= WC_RST_VAL;
		end
		else if (wr_en && adr_i == ADR_BOCTL)
		begin
			bc_swen_r <= dat_i[BC_SWEN];
			bc_fast_r <= dat_i[BC_FAST];
		end
		else if (wr_en && adr_i == ADR_WDCTL)
			wdctl_r <= dat_i[7:0] & WC_MASK;
	end

	assign sw_bor_enable_o  = bc_swen_r;
	assign bor_fast_start_o = bc_fast_r;
	assign wdt_prescale_o   = wdctl_r[5:1];
	assign wdt_sw_enable_o  = wdctl_r[0];

	// Sequencer configuration, loaded only by rst_i, kept across detector and core resets
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cfg_r <= CFG_RST_VAL;
		else if (wr_en && adr_i == ADR_CONFIG)
			cfg_r <= dat_i[7:0] & CFG_MASK;
	end

	// ==========================================================
	// Wishbone answer: one-cycle ack, registered read data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= 32'h0000_0000;
			// Unmapped and unimplemented bits read as zero
			if (adr_i == ADR_CAUSE)
				dat_o[7:0] <= cause_r & CF_MASK;
			else if (adr_i == ADR_STATUS)
				dat_o[7:0] <= status_r;
			else if (adr_i == ADR_BOCTL)
				dat_o[7:0] <= {bc_swen_r, bc_fast_r, 5'h00, sync2_r[SY_BRDY]};
			else if (adr_i == ADR_WDCTL)
				dat_o[7:0] <= wdctl_r;
			else if (adr_i == ADR_CONFIG)
				dat_o[7:0] <= cfg_r;
			else if (adr_i == ADR_SEQST)
				dat_o[7:0] <= {3'h0, pwrt_done, osc_wait_done, state_r};
		end
	end

endmodule : reset_sequencer
`default_nettype wire

// ### tb/reset_seq_chk.sv
// Checker: bus answer, sequencing and vector assertions on sequencer ports.
// Assumes one clock and the synchronous active-high power-on reset.
`timescale 1ns/100ps
`default_nettype none
module reset_seq_chk
	import reset_seq_pkg::*;
#(
	parameter int PWRT_TICKS = 2048,
	parameter int OSC_TICKS  = 1024
) (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Events
	input wire logic        prog_exit_i,
	input wire logic        wdt_timeout_i,
	input wire logic        reset_instr_i,
	input wire logic        sleep_enter_i,
	input wire logic        irq_wake_i,
	input wire logic        global_irq_enable_i,
	// Core control
	input wire logic        core_reset_o,
	input wire logic        core_run_o,
	input wire logic        pc_load_o,
	input wire logic [14:0] pc_value_o,
	input wire logic        pc_advance_o,
	input wire logic        pc_push_o
);
	// ======
	// Clocking and sequences
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_asleep;
		!core_run_o && !core_reset_o && !pc_advance_o;
	endsequence
	sequence s_vector;
		pc_advance_o ##1 (pc_push_o && pc_load_o && pc_value_o == PC_IRQ_VEC);
	endsequence

	// ======
	// Assertions
	chk_ack_pulse:
	assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer is not one cycle");
	chk_upper_zero:
	assert property (ack_o && !$past(we_i) && $past(adr_i) > ADR_SEQST |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_prog_exit:
	assert property (prog_exit_i |-> ##[1:4] core_reset_o)
		else $error("programming exit gave no reset");
	chk_wdt_run:
	assert property (core_run_o && wdt_timeout_i |=> core_reset_o)
		else $error("watchdog reset not taken");
	chk_instr_run:
	assert property (core_run_o && reset_instr_i |=> core_reset_o)
		else $error("reset instruction not taken");
	chk_irq_vector:
	assert property (s_asleep ##0 (irq_wake_i && global_irq_enable_i) |=> s_vector)
		else $error("interrupt wake did not vector");
	chk_wdt_wake:
	assert property (s_asleep ##0 wdt_timeout_i |=> pc_advance_o && core_run_o && !pc_load_o)
		else $error("watchdog wake did not advance");
	chk_reset_vec:
	assert property (core_run_o && $past(core_reset_o) |-> pc_load_o && pc_value_o == PC_RESET_VEC)
		else $error("run began without reset vector");
	chk_sleep_entry:
	assert property (core_run_o && sleep_enter_i |=> !core_run_o && !core_reset_o)
		else $error("sleep not entered");
	chk_run_entry:
	assert property (core_run_o && !$past(core_run_o) |-> pc_load_o || pc_advance_o)
		else $error("run began without vector or advance");
endmodule : reset_seq_chk

bind reset_sequencer reset_seq_chk #(.PWRT_TICKS(PWRT_TICKS), .OSC_TICKS(OSC_TICKS)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .prog_exit_i(prog_exit_i),
	.wdt_timeout_i(wdt_timeout_i), .reset_instr_i(reset_instr_i),
	.sleep_enter_i(sleep_enter_i), .irq_wake_i(irq_wake_i),
	.global_irq_enable_i(global_irq_enable_i), .core_reset_o(core_reset_o),
	.core_run_o(core_run_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
	.pc_advance_o(pc_advance_o), .pc_push_o(pc_push_o));
`default_nettype wire

// ### tb/supply_pin_model.sv
// Model of supply detectors, the pulled-up reset pin and two oscillators.
// Assumes the bench raises supply and pin requests on clk_i edges.
`timescale 1ns/100ps
`default_nettype none
module supply_pin_model (
	// Clock and requests
	input  wire logic clk_i,
	input  wire logic por_req_i,
	input  wire logic bor_req_i,
	input  wire logic lpb_req_i,
	input  wire logic pin_low_i,
	// Lines to the sequencer
	output logic      por_det_o,
	output logic      bor_det_o,
	output logic      low_power_brownout_det_o,
	output logic      pin_n_o,
	output logic      bor_ready_o,
	output logic      lf_osc_o,
	output logic      sel_osc_o
);
	logic [3:0] div_r = 4'h0;

	// Divider: slow oscillator period 12 clocks, selected one 4
	always_ff @(posedge clk_i)
	begin
		div_r <= (div_r == 4'hB) ? 4'h0 : div_r + 4'h1;
	end
	assign lf_osc_o    = (div_r < 4'h6);
	assign sel_osc_o   = div_r[1];
	// Detectors follow requests; released pin is pulled up
	assign por_det_o   = por_req_i;
	assign bor_det_o   = bor_req_i;
	assign low_power_brownout_det_o = lpb_req_i;
	assign pin_n_o     = !pin_low_i;
	assign bor_ready_o = !bor_req_i;
endmodule : supply_pin_model
`default_nettype wire

// ### tb/reset_sequencer_tb.sv
// Self-checking bench for the reset sequencer.
// Assumes the model oscillators outpace the shortened timers.
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer_tb
	import reset_seq_pkg::*;
;
	logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, irq_en = 1'h0;
	logic        por_q = 1'h0, bor_q = 1'h0, lpb_q = 1'h0, pin_q = 1'h0;
	logic [7:0]  adr = 8'h00, cf, st;
	logic [3:0]  sel = 4'h0, s;
	logic [31:0] dat = 32'h0, rdat, v, dat_o;
	logic [6:0]  evt = 7'h00;
	logic        ack_o, core_reset_o, core_run_o, pc_load_o, pc_advance_o, pc_push_o;
	logic        sw_bor_o, fast_o, wdt_en_o, por_d, bor_d, lpb_d, pin_n, rdy, lfo, selo;
	logic [14:0] pc_value_o;
	logic [4:0]  wdt_ps_o;
	int          err_count = 0, checks = 0;

	// ======
	// Instances
	supply_pin_model model_u (.clk_i(clk_i), .por_req_i(por_q), .bor_req_i(bor_q),
		.lpb_req_i(lpb_q), .pin_low_i(pin_q), .por_det_o(por_d), .bor_det_o(bor_d),
		.low_power_brownout_det_o(lpb_d), .pin_n_o(pin_n), .bor_ready_o(rdy), .lf_osc_o(lfo), .sel_osc_o(selo));
	reset_sequencer #(.PWRT_TICKS(4), .OSC_TICKS(3)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .por_det_i(por_d), .bor_det_i(bor_d),
		.low_power_brownout_det_i(lpb_d), .external_reset_pin_n_i(pin_n), .bor_ready_i(rdy),
		.lf_osc_i(lfo), .sel_osc_i(selo), .prog_exit_i(evt[0]), .wdt_timeout_i(evt[1]),
		.reset_instr_i(evt[2]), .stack_ovf_i(evt[3]), .stack_unf_i(evt[4]),
		.sleep_enter_i(evt[5]), .irq_wake_i(evt[6]), .global_irq_enable_i(irq_en),
		.core_reset_o(core_reset_o), .core_run_o(core_run_o), .pc_load_o(pc_load_o),
		.pc_value_o(pc_value_o), .pc_advance_o(pc_advance_o), .pc_push_o(pc_push_o),
		.sw_bor_enable_o(sw_bor_o), .bor_fast_start_o(fast_o), .wdt_prescale_o(wdt_ps_o),
		.wdt_sw_enable_o(wdt_en_o));

	// ======
	// Expected {status, cause} after an event
	function automatic logic [15:0] nxt(input int k, input logic [7:0] a, input logic [7:0] c);
		case (k)
			0: return {8'h18, 8'h1C};
			1: return {a & 8'hEF, c & 8'hEF};
			2: return {a, c & 8'hFB};
			3: return {a, c | 8'h80};
			4: return {a, c | 8'h40};
			7: return {a & 8'h07, c};
			8: return {(a & 8'h07) | 8'h18, (c & 8'h02) | 8'h1C};
			9: return {a, c & 8'hF7};
			10: return {(a & 8'h07) | 8'h10, c & 8'hF7};
			default: return {(a & 8'h07) | 8'h10, c};
		endcase
	endfunction : nxt

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Classic single bus cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= m;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'h1 && n < 20);
		rdat = dat_o;
		if (n >= 20)
			err_count++;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb

	// Register read and compare, flags pair, run wait
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'h0, a, 32'h0, 4'hF);
		chk(rdat, {24'h0, e});
	endtask : rd
	task automatic regs();
		rd(ADR_STATUS, st);
		rd(ADR_CAUSE, cf);
	endtask : regs
	task automatic wait_run();
		int n;
		n = 0;
		while (core_run_o !== 1'h1 && n < 300)
		begin
			@(negedge clk_i);
			n++;
		end
		chk(core_run_o, 1'h1);
	endtask : wait_run

	// Event pulse, expected reset level, then flags
	task automatic step(input int k, input int kk, input logic r);
		@(posedge clk_i);
		evt <= 7'(7'h01 << k);
		@(posedge clk_i);
		evt <= 7'h00;
		@(negedge clk_i);
		chk(core_reset_o, r);
		{st, cf} = nxt(kk, st, cf);
		if (k != 5)
			wait_run();
		regs();
	endtask : step

	// Pin press, then release
	task automatic pin(input int kk);
		@(posedge clk_i);
		pin_q <= 1'h1;
		repeat (8) @(negedge clk_i);
		chk(core_reset_o, 1'h1);
		@(posedge clk_i);
		pin_q <= 1'h0;
		{st, cf} = nxt(kk, st, cf);
		wait_run();
		regs();
	endtask : pin

	// Supply event {por, low_power_brownout, bor}, pin optionally held
	task automatic sup(input logic [2:0] m, input logic hold);
		@(posedge clk_i);
		{por_q, lpb_q, bor_q} <= m;
		pin_q <= hold;
		repeat (6) @(posedge clk_i);
		{por_q, lpb_q, bor_q} <= 3'h0;
		repeat (20) @(negedge clk_i);
		{st, cf} = nxt(m[2] ? 0 : 8, st, cf);
	endtask : sup

	// Verdict
	task automatic summarize();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// Clock
	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end
	// Watchdog: tests need well under 5000 cycles
	initial
	begin
		#100000;
		err_count++;
		summarize();
	end

	// Main sequence
	initial
	begin
		v = $urandom(32'h5652);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		{st, cf} = nxt(0, 8'h00, 8'h00);
		wait_run();
		regs();
		chk({sw_bor_o, fast_o, wdt_en_o, wdt_ps_o}, 8'h8B);
		rd(ADR_BOCTL, {7'h40, rdy});
		rd(ADR_WDCTL, 8'h16);
		rd(ADR_CONFIG, 8'h05);
		wb(1'h1, 8'h18, 32'hFF, 4'hF);
		rd(8'h18, 8'h00);
		repeat (6)
		begin
			v = $urandom;
			s = 4'($urandom);
			wb(1'h1, ADR_STATUS, v, s);
			wb(1'h1, ADR_CAUSE, v >> 8, s);
			if (s[0])
				{st, cf} = {(st & 8'h18) | (v[7:0] & 8'h07), v[15:8] & 8'hDF};
			regs();
		end
		wb(1'h1, ADR_CAUSE, 32'h1F, 4'h1);
		cf = 8'h1F;
		step(3, 3, 1'h0);
		wb(1'h1, ADR_CONFIG, 32'h0D, 4'h1);
		step(4, 4, 1'h1);
		wb(1'h1, ADR_CAUSE, 32'h1F, 4'h1);
		cf = 8'h1F;
		step(1, 1, 1'h1);
		step(2, 2, 1'h1);
		pin(9);
		irq_en <= 1'h1;
		step(5, 5, 1'h0);
		step(6, 6, 1'h0);
		step(5, 5, 1'h0);
		step(1, 7, 1'h0);
		step(5, 5, 1'h0);
		pin(10);
		sup(3'h1, 1'h0);
		wait_run();
		regs();
		wb(1'h1, ADR_CONFIG, 32'h06, 4'h1);
		sup(3'h1, 1'h1);
		chk(core_run_o, 1'h0);
		repeat (80) @(negedge clk_i);
		wb(1'h0, ADR_SEQST, 32'h0, 4'hF);
		chk(rdat & 32'h18, 32'h18);
		@(posedge clk_i);
		pin_q <= 1'h0;
		repeat (8) @(negedge clk_i);
		chk(core_run_o, 1'h1);
		regs();
		sup(3'h1, 1'h0);
		chk(core_run_o, 1'h0);
		wait_run();
		wb(1'h1, ADR_CONFIG, 32'h15, 4'h1);
		sup(3'h2, 1'h0);
		wait_run();
		regs();
		sup(3'h4, 1'h0);
		wait_run();
		regs();
		step(0, 0, 1'h1);
		summarize();
	end
endmodule : reset_sequencer_tb
`default_nettype wire
